// file: cps_operator.sv
// Operator model driving the front-panel keys, switches and input terminals.
`timescale 1ns/1ps
module cps_operator (
  input wire logic core_clk_in,
  output logic [7:0] keys_out,
  output logic [3:0] sw_out,
  output logic lock_out,
  output logic cnt_out,
  output logic clren_out
);
  // Keys: [4:0] digits with [4] leftmost, [5] preset, [6] enter, [7] clear.
  initial
  begin
    keys_out = 8'h00;
    sw_out = 4'h0;
    lock_out = 1'b1;
    cnt_out = 1'b1;
    clren_out = 1'b1;
  end
  task hold(input logic [7:0] k);
    keys_out <= k;
    repeat (6) @(posedge core_clk_in);
    keys_out <= 8'h00;
    repeat (10) @(posedge core_clk_in);
  endtask : hold
  // The count terminal idles high on its pull-up between pulses.
  task pulse();
    cnt_out <= 1'b0;
    repeat (6) @(posedge core_clk_in);
    cnt_out <= 1'b1;
    repeat (6) @(posedge core_clk_in);
  endtask : pulse
endmodule : cps_operator

// file: cps_pkg.sv
// Package of constants and types for the counter panel self-test sequencer.
package cps_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned STEP_MS = 500;
  localparam int unsigned IDLE_S = 18;
  localparam logic [10:0] STEP_TICKS = 11'(STEP_MS / TICK_MS);
  localparam logic [10:0] IDLE_TICKS = 11'(IDLE_S * 1000 / TICK_MS);
  localparam logic [4:0] PAT_STEPS = 5'h14;
  localparam logic [4:0] PAT_BLANK = 5'h0A;
  localparam logic [4:0] PAT_PAIR0 = 5'h0B;
  localparam logic [7:0] ADDR_PRESET = 8'h00;
  localparam logic [7:0] ADDR_TIMED = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [23:0] PRESET_RST = 24'h000500;
  localparam logic [13:0] TIMED_RST = 14'h000A;
  localparam logic [13:0] TIMED_MAX = 14'h270F;
  localparam logic [23:0] COUNT_RST = 24'h000000;
  localparam int ST_TEST = 0;
  localparam int ST_OUT = 1;
  localparam int ST_LOCK = 2;
  localparam int ST_TESTED = 3;
  localparam int ST_STEP = 8;
  localparam int ST_STATE = 13;
  localparam int ST_MODE = 16;
  typedef enum logic [1:0] {CPS_IDLE, CPS_PAT, CPS_LOCK, CPS_MODE} cps_state_t;
  typedef struct packed {
    logic [7:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } cps_apb_req_t;
  typedef struct packed {
    logic [23:0] digits;
    logic [5:0] blank;
  } cps_disp_t;
endpackage : cps_pkg

// file: cps_self_test.sv
// Pulse counter core with its front-panel self-test sequencer.
`timescale 1ns/1ps
module cps_self_test #(
  parameter int unsigned TICK_CYC = cps_pkg::TICK_CYC
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire cps_pkg::cps_apb_req_t apb_req_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [4:0] digit_btn_in,
  input wire logic preset_key_in,
  input wire logic enter_key_in,
  input wire logic clear_key_in,
  input wire logic [3:0] mode_sw_down_in,
  input wire logic clear_enable_switch_in,
  input wire logic program_lock_input_in,
  input wire logic count_pulse_input_in,
  output cps_pkg::cps_disp_t disp_out,
  output logic output_out,
  output logic self_test_out
);
  localparam int TW = $clog2(TICK_CYC);

  if (TICK_CYC < 2)
  begin : g_bad_tick
    $error("TICK_CYC must be at least 2");
  end

  logic [14:0] pin_a_r, pin_r, pin_q_r;
  logic [TW-1:0] tick_cnt_r;
  logic tick_r;
  cps_pkg::cps_state_t state_r;
  logic [4:0] step_r;
  logic [10:0] stmr_r;
  logic armed_r;
  logic [3:0] mode_r;
  logic clren_r;
  logic [23:0] cnt_r, preset_r, cnt_inc;
  logic [13:0] tmo_r, otmr_r;
  logic norm_out_r, test_on_r, tested_r, out_r;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r, rdata;
  cps_pkg::cps_disp_t disp_r, disp_nxt;
  logic [7:0] btn_s, btn_q, press, rel;
  logic [3:0] sw_s;
  logic lock_s, cnt_fall, in_test, activity, step_done, adv;
  logic unit_rst, go_idle, hit, apb_acc, apb_wr;
  logic [6:0] carry;
  logic [3:0] pj, pa, pb;

  // Every pin passes two flip-flops; pin_q_r keeps the last settled value.
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      pin_a_r <= '0;
      pin_r <= '0;
      pin_q_r <= '0;
    end
    else
    begin
      pin_a_r <= {count_pulse_input_in, program_lock_input_in,
                  clear_enable_switch_in, mode_sw_down_in, clear_key_in,
                  enter_key_in, preset_key_in, digit_btn_in};
      pin_r <= pin_a_r;
      pin_q_r <= pin_r;
    end
  end

  assign btn_s = pin_r[7:0];
  assign btn_q = pin_q_r[7:0];
  assign press = btn_s & ~btn_q;
  assign rel = ~btn_s & btn_q;
  assign sw_s = pin_r[11:8];
  assign lock_s = ~pin_r[13];
  assign cnt_fall = pin_q_r[14] & ~pin_r[14];
  assign in_test = (state_r != cps_pkg::CPS_IDLE);
  assign activity = (pin_r[12:0] != pin_q_r[12:0]);

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (tick_cnt_r == TW'(TICK_CYC - 1));
      if (tick_cnt_r == TW'(TICK_CYC - 1))
        tick_cnt_r <= '0;
      else
        tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  assign unit_rst = press[7] && !btn_s[5] && (in_test || clren_r);
  assign step_done = tick_r && (stmr_r == cps_pkg::STEP_TICKS - 11'h001);
  assign adv = (armed_r && (|rel[6:0])) || step_done;
  always_comb
  begin
    go_idle = 1'b0;
    if (in_test && unit_rst)
      go_idle = 1'b1;
    else if (state_r == cps_pkg::CPS_MODE)
      go_idle = rel[6] || (!activity && tick_r &&
                (stmr_r == cps_pkg::IDLE_TICKS - 11'h001));
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      state_r <= cps_pkg::CPS_IDLE;
      step_r <= '0;
      stmr_r <= '0;
      armed_r <= 1'b0;
    end
    else if (go_idle)
      state_r <= cps_pkg::CPS_IDLE;
    else
    begin
      if (btn_s[6:0] == 7'h00)
        armed_r <= 1'b1;
      case (state_r)
        cps_pkg::CPS_IDLE:
          if (btn_s[4] && btn_s[3] && !btn_s[7])
          begin
            state_r <= cps_pkg::CPS_PAT;
            step_r <= '0;
            stmr_r <= '0;
            armed_r <= 1'b0;
          end
        cps_pkg::CPS_PAT:
          if (adv)
          begin
            stmr_r <= '0;
            if (step_r == cps_pkg::PAT_STEPS - 5'h01)
              state_r <= cps_pkg::CPS_LOCK;
            else
              step_r <= step_r + 5'h01;
          end
          else if (tick_r)
            stmr_r <= stmr_r + 11'h001;
        cps_pkg::CPS_LOCK:
          if (adv)
          begin
            stmr_r <= '0;
            state_r <= cps_pkg::CPS_MODE;
          end
          else if (tick_r)
            stmr_r <= stmr_r + 11'h001;
        cps_pkg::CPS_MODE:
          if (activity)
            stmr_r <= '0;
          else if (tick_r)
            stmr_r <= stmr_r + 11'h001;
        default:
          state_r <= cps_pkg::CPS_IDLE;
      endcase
    end
  end

  // Switches steer the counter only outside self-test.
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      mode_r <= '0;
      clren_r <= 1'b0;
    end
    else if (!in_test)
    begin
      mode_r <= sw_s;
      clren_r <= pin_r[12];
    end
  end

  assign carry[0] = 1'b1;
  for (genvar i = 0; i < 6; i++)
  begin : g_bcd
    assign carry[i+1] = carry[i] && (cnt_r[4*i+:4] == 4'h9);
    assign cnt_inc[4*i+:4] = !carry[i] ? cnt_r[4*i+:4] :
                             (cnt_r[4*i+:4] == 4'h9) ? 4'h0 :
                             cnt_r[4*i+:4] + 4'h1;
  end
  assign hit = (cnt_inc == preset_r);

  // The counter keeps counting in self-test; there the clear key resets it regardless of clren_r.
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      cnt_r <= cps_pkg::COUNT_RST;
    else if (unit_rst)
      cnt_r <= '0;
    else if (cnt_fall)
      cnt_r <= (mode_r != 4'h0 && hit) ? '0 : cnt_inc;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      norm_out_r <= 1'b0;
      otmr_r <= '0;
    end
    else if (unit_rst || (go_idle && tested_r))
      norm_out_r <= 1'b0;
    else if (cnt_fall && hit)
    begin
      norm_out_r <= 1'b1;
      otmr_r <= tmo_r;
    end
    else if (mode_r != 4'h0 && norm_out_r && tick_r)
    begin
      otmr_r <= otmr_r - 14'h0001;
      if (otmr_r <= 14'h0001)
        norm_out_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      test_on_r <= 1'b0;
      tested_r <= 1'b0;
    end
    else if (go_idle || !in_test)
    begin
      test_on_r <= 1'b0;
      tested_r <= 1'b0;
    end
    else if (state_r == cps_pkg::CPS_MODE && press[5] && !lock_s)
    begin
      test_on_r <= 1'b1;
      tested_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      out_r <= 1'b0;
    else
      out_r <= norm_out_r || test_on_r;
  end

  assign pj = 4'(step_r - cps_pkg::PAT_PAIR0);
  assign pa = {pj[3:1], 1'b1};
  assign pb = (pj + 4'h1) & 4'hE;
  always_comb
  begin
    disp_nxt.digits = cnt_r;
    disp_nxt.blank = 6'h00;
    case (state_r)
      cps_pkg::CPS_PAT:
        if (step_r < cps_pkg::PAT_BLANK)
          disp_nxt.digits = {6{step_r[3:0]}};
        else if (step_r == cps_pkg::PAT_BLANK)
          disp_nxt.blank = 6'h3F;
        else
          disp_nxt.digits = {pa, pb, pa, pb, pa, pb};
      cps_pkg::CPS_LOCK:
      begin
        disp_nxt.digits = {12'h000, 3'h0, lock_s, 8'h00};
        disp_nxt.blank = 6'h03;
      end
      cps_pkg::CPS_MODE:
      begin
        disp_nxt.digits = {3'h0, sw_s[3], 3'h0, sw_s[2], 3'h0, sw_s[1],
                           3'h0, sw_s[0], 8'h00};
        disp_nxt.blank = 6'h03;
      end
      default:
        disp_nxt.blank = 6'h00;
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      disp_r <= '0;
    else
      disp_r <= disp_nxt;
  end

  // One wait state: pready rises in the second access cycle.
  assign apb_acc = psel_in && penable_in && pready_r;
  assign apb_wr = apb_acc && apb_req_in.pwrite && !lock_s;
  always_comb
  begin
    rdata = '0;
    case (apb_req_in.paddr)
      cps_pkg::ADDR_PRESET:
        rdata = {8'h00, preset_r};
      cps_pkg::ADDR_TIMED:
        rdata = {18'h00000, tmo_r};
      cps_pkg::ADDR_COUNT:
        rdata = {8'h00, cnt_r};
      cps_pkg::ADDR_STATUS:
      begin
        rdata[cps_pkg::ST_TEST] = in_test;
        rdata[cps_pkg::ST_OUT] = out_r;
        rdata[cps_pkg::ST_LOCK] = lock_s;
        rdata[cps_pkg::ST_TESTED] = tested_r;
        rdata[cps_pkg::ST_STEP+:5] = step_r;
        rdata[cps_pkg::ST_STATE+:2] = state_r;
        rdata[cps_pkg::ST_MODE+:4] = mode_r;
      end
      default:
        rdata = '0;
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
    else
    begin
      pready_r <= psel_in && penable_in && !pready_r;
      if (psel_in && penable_in && !pready_r)
      begin
        prdata_r <= apb_req_in.pwrite ? 32'h00000000 : rdata;
        pslverr_r <= (apb_req_in.paddr != cps_pkg::ADDR_PRESET) &&
                     (apb_req_in.paddr != cps_pkg::ADDR_TIMED) &&
                     (apb_req_in.paddr != cps_pkg::ADDR_COUNT) &&
                     (apb_req_in.paddr != cps_pkg::ADDR_STATUS);
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      preset_r <= cps_pkg::PRESET_RST;
      tmo_r <= cps_pkg::TIMED_RST;
    end
    else if (apb_wr)
    begin
      if (apb_req_in.paddr == cps_pkg::ADDR_PRESET)
        preset_r <= apb_req_in.pwdata[23:0];
      if (apb_req_in.paddr == cps_pkg::ADDR_TIMED &&
          apb_req_in.pwdata[13:0] != 14'h0000 &&
          apb_req_in.pwdata[13:0] <= cps_pkg::TIMED_MAX)
        tmo_r <= apb_req_in.pwdata[13:0];
    end
  end

  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign disp_out = disp_r;
  assign output_out = out_r;
  assign self_test_out = (state_r != cps_pkg::CPS_IDLE);

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  chk_entry_keys: assert property (
    (state_r == cps_pkg::CPS_IDLE && btn_s[4] && btn_s[3] && !btn_s[7])
    |=> (state_r == cps_pkg::CPS_PAT && step_r == 5'h00))
    else $error("self-test not entered on both left keys");
  chk_step_time: assert property (
    (state_r == cps_pkg::CPS_PAT && step_done && !go_idle &&
     step_r != cps_pkg::PAT_STEPS - 5'h01)
    |=> (step_r == $past(step_r) + 5'h01 && stmr_r == 11'h000))
    else $error("pattern step did not advance on time");
  chk_clear_exit: assert property (
    (in_test && press[7] && !btn_s[5]) |=> !in_test ##1 !self_test_out)
    else $error("clear key did not end self-test");
  chk_lock_digit: assert property (
    (state_r == cps_pkg::CPS_LOCK)
    |=> (disp_out.digits[11:8] == {3'h0, $past(lock_s)}))
    else $error("lock digit wrong");
  chk_mode_freeze: assert property (
    in_test |=> (mode_r == $past(mode_r)))
    else $error("mode changed during self-test");
  chk_test_refused: assert property (
    (state_r == cps_pkg::CPS_MODE && lock_s && !test_on_r)
    |=> !test_on_r)
    else $error("output test allowed while locked");
  chk_tested_off: assert property (
    (go_idle && tested_r) |=> (!norm_out_r && !test_on_r) ##1 !output_out)
    else $error("tested output not off after exit");
  chk_idle_exit: assert property (
    (state_r == cps_pkg::CPS_MODE && !activity && tick_r &&
     stmr_r == cps_pkg::IDLE_TICKS - 11'h001) |=> !in_test)
    else $error("inactivity timeout did not exit");
  chk_count_edge: assert property (
    (cnt_fall && !unit_rst && !hit) |=> (cnt_r != $past(cnt_r)))
    else $error("count edge lost");
endmodule : cps_self_test

// file: test_counter_panel_self_test_sequencer.sv
// Self-checking testbench for the counter panel self-test sequencer.
`timescale 1ns/1ps
module test_counter_panel_self_test_sequencer;
  localparam int T = 10;
  logic clk, rst, psel, pen, prdy, perr, st, outp, rerr, lock, cnt, clren;
  logic [31:0] prd, rdat;
  logic [7:0] keys;
  logic [3:0] sw;
  cps_pkg::cps_apb_req_t req;
  cps_pkg::cps_disp_t disp;
  int miscompares, n_compared, seed, count_m, out_m;
  cps_operator op (.core_clk_in(clk), .keys_out(keys), .sw_out(sw),
    .lock_out(lock), .cnt_out(cnt), .clren_out(clren));
  cps_self_test #(.TICK_CYC(T)) uut (.core_clk_in(clk), .sys_rst_in(rst),
    .psel_in(psel), .penable_in(pen), .apb_req_in(req), .prdata_out(prd),
    .pready_out(prdy), .pslverr_out(perr), .digit_btn_in(keys[4:0]),
    .preset_key_in(keys[5]), .enter_key_in(keys[6]),
    .clear_key_in(keys[7]), .mode_sw_down_in(sw),
    .clear_enable_switch_in(clren), .program_lock_input_in(lock),
    .count_pulse_input_in(cnt), .disp_out(disp), .output_out(outp),
    .self_test_out(st));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task summarize();
    if (miscompares == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; pready is sampled at each rising edge of the access.
  // An idle edge follows so that back to back calls never drive psel twice.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    req <= '{a, w, d};
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (prdy !== 1'b1);
    rdat = prd;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  function automatic logic [23:0] pat(input int k);
    int o, e;
    o = 2 * ((k - 11) / 2) + 1;
    e = 2 * ((k - 10) / 2);
    if (k < 10)
      return {6{4'(k)}};
    return {3{4'(o), 4'(e)}};
  endfunction : pat
  task enter();
    op.hold(8'h18);
    chk(st, 1'b1);
  endtask : enter
  task walk(input int first, input logic [3:0] lk);
    for (int k = first; k < 20; k++)
    begin
      op.hold(8'h01 << (k % 7));
      if (k == 10)
        chk(disp.blank, 6'h3F);
      else
        chk(disp, {pat(k), 6'h00});
    end
    op.hold(8'h01);
    chk({disp.digits[23:8], disp.blank}, {12'h000, lk, 6'h03});
    op.hold(8'h01);
  endtask : walk
  task sws(input int n);
    logic [31:0] v;
    repeat (n)
    begin
      v = $random(seed);
      op.sw_out <= v[3:0];
      repeat (8) @(posedge clk);
      chk({disp.digits[23:8], disp.blank}, {3'h0, v[3], 3'h0, v[2],
        3'h0, v[1], 3'h0, v[0], 6'h03});
    end
  endtask : sws
  initial
  begin
    seed = 63;
    miscompares = 0;
    n_compared = 0;
    count_m = 0;
    out_m = 0;
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    req = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(disp, 30'h0);
    chk({st, outp}, 2'b00);
    rd(cps_pkg::ADDR_PRESET);
    chk(rdat, 32'h500);
    rd(cps_pkg::ADDR_TIMED);
    chk(rdat, 32'hA);
    rd(cps_pkg::ADDR_COUNT);
    chk(rdat, 32'h0);
    rd(8'h10);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    apb(1'b1, cps_pkg::ADDR_PRESET, 32'h4);
    op.lock_out <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b1, cps_pkg::ADDR_PRESET, 32'h9);
    apb(1'b1, cps_pkg::ADDR_TIMED, 32'h5);
    rd(cps_pkg::ADDR_PRESET);
    chk(rdat, 32'h4);
    rd(cps_pkg::ADDR_TIMED);
    chk(rdat, 32'hA);
    op.lock_out <= 1'b1;
    repeat (3)
    begin
      op.pulse();
      count_m++;
    end
    rd(cps_pkg::ADDR_COUNT);
    chk(rdat, count_m);
    chk(outp, 1'b0);
    op.pulse();
    count_m++;
    out_m = 1;
    chk(outp, out_m);
    op.lock_out <= 1'b0;
    enter();
    chk(outp, out_m);
    repeat (40 * T) @(posedge clk);
    chk(disp, {pat(0), 6'h00});
    repeat (20 * T) @(posedge clk);
    chk(disp, {pat(1), 6'h00});
    op.pulse();
    count_m++;
    rd(cps_pkg::ADDR_COUNT);
    chk(rdat, count_m);
    walk(2, 4'h1);
    sws(3);
    op.sw_out <= 4'h0;
    rd(cps_pkg::ADDR_STATUS);
    chk(rdat[19:16], 4'h0);
    op.hold(8'h20);
    rd(cps_pkg::ADDR_STATUS);
    chk(rdat[3], 1'b0);
    repeat (1700 * T) @(posedge clk);
    chk(st, 1'b1);
    repeat (200 * T) @(posedge clk);
    chk(st, 1'b0);
    chk(outp, out_m);
    op.clren_out <= 1'b0;
    repeat (4) @(posedge clk);
    op.hold(8'h80);
    chk(outp, out_m);
    rd(cps_pkg::ADDR_COUNT);
    chk(rdat, count_m);
    op.clren_out <= 1'b1;
    op.lock_out <= 1'b1;
    enter();
    op.hold(8'h80);
    count_m = 0;
    out_m = 0;
    chk({st, outp}, 2'b00);
    rd(cps_pkg::ADDR_COUNT);
    chk(rdat, count_m);
    repeat (4)
    begin
      op.pulse();
      count_m++;
    end
    chk(outp, 1'b1);
    enter();
    walk(1, 4'h0);
    op.sw_out <= 4'h1;
    repeat (8) @(posedge clk);
    op.hold(8'h20);
    chk(outp, 1'b1);
    rd(cps_pkg::ADDR_STATUS);
    chk({rdat[19:16], rdat[3]}, 5'h01);
    op.hold(8'h40);
    chk({st, outp}, 2'b00);
    rd(cps_pkg::ADDR_STATUS);
    chk(rdat[19:16], 4'h1);
    apb(1'b1, cps_pkg::ADDR_PRESET, 32'h5);
    op.pulse();
    chk(outp, 1'b1);
    rd(cps_pkg::ADDR_COUNT);
    chk(rdat, 32'h0);
    repeat (12 * T) @(posedge clk);
    chk(outp, 1'b0);
    summarize();
  end
  initial
  begin
    #(8 * 60000);
    miscompares++;
    summarize();
  end
endmodule : test_counter_panel_self_test_sequencer
